// File: logic/timer16_pkg.sv
// Shared constants, types and helpers for the 16-bit timer core
package timer16_pkg;

    localparam int          BYTE_W         = 8;
    localparam int          CNT_W          = 16;
    localparam int          PRE_W          = 10;
    localparam int          FILTER_SAMPLES = 4;

    // Count limits and fixed ceilings
    localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
    localparam logic [15:0] COUNT_FLOOR    = 16'h0000;
    localparam logic [15:0] TOP_8BIT       = 16'h00FF;
    localparam logic [15:0] TOP_9BIT       = 16'h01FF;
    localparam logic [15:0] TOP_10BIT      = 16'h03FF;

    // Reset values
    localparam logic [15:0] COUNT_RESET    = 16'h0000;
    localparam logic [15:0] CAPTURE_RESET  = 16'h0000;
    localparam logic [7:0]  LATCH_RESET    = 8'h00;
    localparam logic [7:0]  RDATA_RESET    = 8'h00;
    localparam logic [9:0]  PRE_RESET      = 10'h000;

    // Bit positions in the flag byte
    localparam int          FLAG_OVERFLOW_BIT = 0;
    localparam int          FLAG_CAPTURE_BIT  = 5;

    // Clock-select codes
    localparam logic [2:0]  CS_STOP        = 3'h0;
    localparam logic [2:0]  CS_DIV1        = 3'h1;
    localparam logic [2:0]  CS_DIV8        = 3'h2;
    localparam logic [2:0]  CS_DIV64       = 3'h3;
    localparam logic [2:0]  CS_DIV256      = 3'h4;
    localparam logic [2:0]  CS_DIV1024     = 3'h5;
    localparam logic [2:0]  CS_EXT_FALL    = 3'h6;
    localparam logic [2:0]  CS_EXT_RISE    = 3'h7;

    localparam logic [3:0]  WM_NORMAL      = 4'h0;

    typedef enum logic [2:0] {
        ADDR_COUNT_LOW    = 3'h0,
        ADDR_COUNT_HIGH   = 3'h1,
        ADDR_CAPTURE_LOW  = 3'h2,
        ADDR_CAPTURE_HIGH = 3'h3,
        ADDR_IRQ_FLAGS    = 3'h4
    } cpu_addr_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        cpu_addr_t  addr;
        logic [7:0] wdata;
    } cpu_req_t;

    typedef struct packed {
        logic [2:0] clk_sel;
        logic [1:0] wave_mode_lo;
        logic [1:0] wave_mode_hi;
        logic       capture_filter_enable;
        logic       edge_rising;
        logic       comparator_capture_select;
        logic       capture_irq_enable;
        logic       overflow_irq_enable;
    } timer_cfg_t;

    typedef enum logic {
        DIR_UP   = 1'b0,
        DIR_DOWN = 1'b1
    } count_dir_t;

    // Modes whose ceiling is the capture register
    function automatic logic capture_is_top(input logic [3:0] mode);
        return (mode == 4'h8) || (mode == 4'hA) || (mode == 4'hC) || (mode == 4'hE);
    endfunction : capture_is_top

    // Modes that count up then down
    function automatic logic dual_slope(input logic [3:0] mode);
        return (mode >= 4'h1 && mode <= 4'h3) || (mode >= 4'h8 && mode <= 4'hB);
    endfunction : dual_slope

    // Single-slope modes whose overflow fires at the ceiling instead of at max
    function automatic logic overflow_at_top(input logic [3:0] mode);
        return (mode >= 4'h5 && mode <= 4'h7) || (mode == 4'hE) || (mode == 4'hF);
    endfunction : overflow_at_top

    function automatic logic [15:0] ceiling_of(input logic [3:0] mode, input logic [15:0] cap);
        logic [15:0] top;
        top = COUNT_MAX;
        if (capture_is_top(mode)) begin
            top = cap;
        end else if (mode[1:0] == 2'h1 && (mode == 4'h1 || mode == 4'h5)) begin
            top = TOP_8BIT;
        end else if (mode == 4'h2 || mode == 4'h6) begin
            top = TOP_9BIT;
        end else if (mode == 4'h3 || mode == 4'h7) begin
            top = TOP_10BIT;
        end
        return top;
    endfunction : ceiling_of

endpackage : timer16_pkg

// File: logic/edge_sampler.sv
// Pin synchroniser, optional four-sample filter and edge detector
`timescale 1ns/1ps
`default_nettype none
module edge_sampler
    import timer16_pkg::*;
(
    input  wire logic i_clk_sys,
    input  wire logic i_rstn,
    input  wire logic i_raw,
    input  wire logic i_enable,
    input  wire logic i_filter_en,
    output logic      o_rise,
    output logic      o_fall
);

    typedef struct packed {
        logic       s1;
        logic       s2;
        logic       s3;
        logic       level;
        logic [3:0] hist;
        logic       filt;
        logic       rise;
        logic       fall;
    } smp_state_t;

    smp_state_t r;
    smp_state_t r_nxt;

    always_comb begin
        r_nxt      = r;
        r_nxt.s1   = i_raw;
        r_nxt.s2   = r.s1;
        r_nxt.s3   = r.s2;
        r_nxt.rise = 1'b0;
        r_nxt.fall = 1'b0;
        // A change counts only once the second and third stages agree
        if (r.s2 == r.s3) begin
            r_nxt.level = r.s3;
        end
        if (i_enable) begin
            r_nxt.hist = {r.hist[2:0], r.level};
            if (!i_filter_en) begin
                r_nxt.filt = r.level;
            end else if (r.hist == {FILTER_SAMPLES{r.hist[0]}}) begin
                r_nxt.filt = r.hist[0];
            end
            r_nxt.rise = r_nxt.filt & ~r.filt;
            r_nxt.fall = ~r_nxt.filt & r.filt;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

    assign o_rise = r.rise;
    assign o_fall = r.fall;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    chk_filter_four_equal: assert property (
        i_filter_en && i_enable && $past(i_filter_en) && (r.filt != $past(r.filt))
        |-> ($past(r.hist) == {4{r.filt}}))
        else $error("filtered level moved without four equal samples");

endmodule : edge_sampler
`default_nettype wire

// File: logic/timer16_count_capture_core.sv
// 16-bit timer core: counter, byte access through a shared latch, input capture
// Notes on behaviour
// - Clock-select picks tick source; zero stops counting.
// - CPU access any time; write beats count.
// - High-byte access uses latch; low read loads it.
// - Low-byte write loads whole counter at once.
// - Counter clears, increments or decrements per tick.
// - Wave mode split across control registers A/B.
// - Overflow flag set per mode; can interrupt.
// - Ceiling and floor indications; clear zeros counter.
// - Edge copies counter to capture, sets flag.
// - Capture flag interrupts; cleared by ack or one.
// - Capture low read loads latch with high byte.
// - Capture writable only when it is ceiling.
// - Select bit switches trigger to comparator output.
// - Capture inputs sampled like external count pin.
// - Filter moves only after four equal samples.
// - Filter adds four system-clock cycles delay.
// - Capture input off in capture-ceiling modes.
// - Driving the pin port triggers a capture.
// - Each capture overwrites the previous value.
// - Maximum is 0xFFFF, floor is 0x0000.
// - Other timer reads leave the latch alone.
`timescale 1ns/1ps
`default_nettype none
module timer16_count_capture_core
    import timer16_pkg::*;
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_rstn,
    input  wire cpu_req_t   i_cpu,
    input  wire timer_cfg_t i_cfg,
    input  wire logic       i_capture_irq_ack,
    input  wire logic       i_overflow_irq_ack,
    input  wire logic       i_capture_pin,
    input  wire logic       i_port_out,
    input  wire logic       i_port_dir,
    input  wire logic       i_comparator_output,
    input  wire logic       i_external_count_pin,
    output logic [7:0]      o_cpu_rdata,
    output logic [15:0]     o_timer_count,
    output logic [15:0]     o_capture_value,
    output logic            o_capture_flag,
    output logic            o_overflow_flag,
    output logic            o_capture_irq,
    output logic            o_overflow_irq,
    output logic            o_ceiling_hit,
    output logic            o_floor_hit
);

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] capture;
        logic [7:0]  latch;
        logic        capture_flag;
        logic        overflow_flag;
        count_dir_t  dir;
        logic [9:0]  prescale;
        logic [7:0]  rdata;
        logic        ceiling_hit;
        logic        floor_hit;
        logic        capture_irq;
        logic        overflow_irq;
    } core_state_t;

    core_state_t r;
    core_state_t r_nxt;

    logic       cap_raw;
    logic       cap_rise;
    logic       cap_fall;
    logic       ext_rise;
    logic       ext_fall;
    logic [3:0] wave_mode_field;
    logic       cap_top_mode;
    logic [15:0] ceiling;
    logic       tick;
    logic       cap_event;
    logic       wr_count_low;
    logic       wr_capture_low;
    logic       cap_clear;
    logic       ovf_clear;
    logic       ovf_set;

    assign wave_mode_field = {i_cfg.wave_mode_hi, i_cfg.wave_mode_lo};
    assign cap_top_mode    = capture_is_top(wave_mode_field);
    assign ceiling         = ceiling_of(wave_mode_field, r.capture);

    // Comparator select replaces the pin; a driven port reflects its output latch
    assign cap_raw = i_cfg.comparator_capture_select ? i_comparator_output
                   : (i_port_dir ? i_port_out : i_capture_pin);

    edge_sampler u_capture_sampler (
        .i_clk_sys   (i_clk_sys),
        .i_rstn      (i_rstn),
        .i_raw       (cap_raw),
        .i_enable    (!cap_top_mode),
        .i_filter_en (i_cfg.capture_filter_enable),
        .o_rise      (cap_rise),
        .o_fall      (cap_fall)
    );

    // Same sampler without filter, so both paths carry equal delay while the capture filter is off
    edge_sampler u_count_sampler (
        .i_clk_sys   (i_clk_sys),
        .i_rstn      (i_rstn),
        .i_raw       (i_external_count_pin),
        .i_enable    (1'b1),
        .i_filter_en (1'b0),
        .o_rise      (ext_rise),
        .o_fall      (ext_fall)
    );

    function automatic logic tick_of(input logic [2:0] sel, input logic [9:0] pre,
                                     input logic rise, input logic fall);
        logic t;
        t = 1'b0;
        unique case (sel)
            CS_STOP:     t = 1'b0;
            CS_DIV1:     t = 1'b1;
            CS_DIV8:     t = (pre[2:0] == 3'h7);
            CS_DIV64:    t = (pre[5:0] == 6'h3F);
            CS_DIV256:   t = (pre[7:0] == 8'hFF);
            CS_DIV1024:  t = (pre == 10'h3FF);
            CS_EXT_FALL: t = fall;
            CS_EXT_RISE: t = rise;
        endcase
        return t;
    endfunction : tick_of

    assign tick = tick_of(i_cfg.clk_sel, r.prescale, ext_rise, ext_fall);

    assign cap_event = !cap_top_mode
                     && (i_cfg.edge_rising ? cap_rise : cap_fall);

    assign wr_count_low   = i_cpu.wr && (i_cpu.addr == ADDR_COUNT_LOW);
    assign wr_capture_low = i_cpu.wr && (i_cpu.addr == ADDR_CAPTURE_LOW) && cap_top_mode;

    assign cap_clear = i_capture_irq_ack
                     || (i_cpu.wr && i_cpu.addr == ADDR_IRQ_FLAGS && i_cpu.wdata[FLAG_CAPTURE_BIT]);
    assign ovf_clear = i_overflow_irq_ack
                     || (i_cpu.wr && i_cpu.addr == ADDR_IRQ_FLAGS && i_cpu.wdata[FLAG_OVERFLOW_BIT]);

    always_comb begin
        r_nxt             = r;
        r_nxt.ceiling_hit = 1'b0;
        r_nxt.floor_hit   = 1'b0;
        ovf_set           = 1'b0;

        // The prescaler idles while stopped so a restart begins a full period
        if (i_cfg.clk_sel == CS_STOP) begin
            r_nxt.prescale = PRE_RESET;
        end else begin
            r_nxt.prescale = r.prescale + 10'h001;
        end

        if (tick) begin
            r_nxt.ceiling_hit = (r.count == ceiling);
            r_nxt.floor_hit   = (r.count == COUNT_FLOOR);
            if (dual_slope(wave_mode_field)) begin
                if (r.dir == DIR_UP) begin
                    if (r.count >= ceiling) begin
                        r_nxt.dir   = DIR_DOWN;
                        r_nxt.count = r.count - 16'h0001;
                    end else begin
                        r_nxt.count = r.count + 16'h0001;
                    end
                end else if (r.count == COUNT_FLOOR) begin
                    r_nxt.dir   = DIR_UP;
                    r_nxt.count = r.count + 16'h0001;
                    ovf_set     = 1'b1;
                end else begin
                    r_nxt.count = r.count - 16'h0001;
                end
            end else begin
                r_nxt.dir = DIR_UP;
                if (r.count >= ceiling) begin
                    r_nxt.count = COUNT_FLOOR;
                    ovf_set     = overflow_at_top(wave_mode_field)
                                || (r.count == COUNT_MAX);
                end else begin
                    r_nxt.count = r.count + 16'h0001;
                end
            end
        end

        // A CPU write overrides any count or clear in the same cycle
        if (wr_count_low) begin
            r_nxt.count = {r.latch, i_cpu.wdata};
        end

        if (cap_event) begin
            r_nxt.capture = r.count;
        end else if (wr_capture_low) begin
            r_nxt.capture = {r.latch, i_cpu.wdata};
        end

        // Set beats clear so an event in the clearing cycle is kept
        r_nxt.capture_flag  = cap_event || (r.capture_flag && !cap_clear);
        r_nxt.overflow_flag = ovf_set || (r.overflow_flag && !ovf_clear);
        r_nxt.capture_irq   = r_nxt.capture_flag && i_cfg.capture_irq_enable;
        r_nxt.overflow_irq  = r_nxt.overflow_flag && i_cfg.overflow_irq_enable;

        // Latch holds between accesses so one high byte may serve several writes
        if (i_cpu.wr && (i_cpu.addr == ADDR_COUNT_HIGH || i_cpu.addr == ADDR_CAPTURE_HIGH)) begin
            r_nxt.latch = i_cpu.wdata;
        end else if (i_cpu.rd && i_cpu.addr == ADDR_COUNT_LOW) begin
            r_nxt.latch = r.count[15:8];
        end else if (i_cpu.rd && i_cpu.addr == ADDR_CAPTURE_LOW) begin
            r_nxt.latch = r.capture[15:8];
        end

        if (i_cpu.rd) begin
            unique case (i_cpu.addr)
                ADDR_COUNT_LOW:    r_nxt.rdata = r.count[7:0];
                ADDR_COUNT_HIGH:   r_nxt.rdata = r.latch;
                ADDR_CAPTURE_LOW:  r_nxt.rdata = r.capture[7:0];
                ADDR_CAPTURE_HIGH: r_nxt.rdata = r.latch;
                ADDR_IRQ_FLAGS: begin
                    r_nxt.rdata                    = 8'h00;
                    r_nxt.rdata[FLAG_CAPTURE_BIT]  = r.capture_flag;
                    r_nxt.rdata[FLAG_OVERFLOW_BIT] = r.overflow_flag;
                end
                // Unused codes read zero and never touch the latch
                default:           r_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            r.count         <= COUNT_RESET;
            r.capture       <= CAPTURE_RESET;
            r.latch         <= LATCH_RESET;
            r.capture_flag  <= 1'b0;
            r.overflow_flag <= 1'b0;
            r.dir           <= DIR_UP;
            r.prescale      <= PRE_RESET;
            r.rdata         <= RDATA_RESET;
            r.ceiling_hit   <= 1'b0;
            r.floor_hit     <= 1'b0;
            r.capture_irq   <= 1'b0;
            r.overflow_irq  <= 1'b0;
        end else begin
            r <= r_nxt;
        end
    end

    assign o_cpu_rdata     = r.rdata;
    assign o_timer_count   = r.count;
    assign o_capture_value = r.capture;
    assign o_capture_flag  = r.capture_flag;
    assign o_overflow_flag = r.overflow_flag;
    assign o_capture_irq   = r.capture_irq;
    assign o_overflow_irq  = r.overflow_irq;
    assign o_ceiling_hit   = r.ceiling_hit;
    assign o_floor_hit     = r.floor_hit;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    chk_stop_holds_count: assert property (
        (i_cfg.clk_sel == CS_STOP) && !wr_count_low |=> $stable(r.count))
        else $error("counter moved while stopped");

    chk_write_beats_count: assert property (
        wr_count_low |=> (r.count == {$past(r.latch), $past(i_cpu.wdata)}))
        else $error("cpu write lost to count action");

    chk_low_read_latch: assert property (
        i_cpu.rd && i_cpu.addr == ADDR_COUNT_LOW && !i_cpu.wr
        |=> (r.latch == $past(r.count[15:8])) && (o_cpu_rdata == $past(r.count[7:0])))
        else $error("latch not loaded on counter low read");

    chk_normal_step: assert property (
        (wave_mode_field == WM_NORMAL) && tick && !wr_count_low && r.count != COUNT_MAX
        |=> (r.count == $past(r.count) + 16'h0001))
        else $error("normal mode did not count up by one");

    chk_overflow_at_max: assert property (
        (wave_mode_field == WM_NORMAL) && tick && !wr_count_low && r.count == COUNT_MAX
        |=> r.overflow_flag && (r.count == COUNT_FLOOR))
        else $error("overflow at max not flagged");

    chk_capture_copy: assert property (
        cap_event |=> (r.capture == $past(r.count)) && r.capture_flag)
        else $error("capture did not stamp counter");

    chk_capture_flag_clear: assert property (
        r.capture_flag && i_capture_irq_ack && !cap_event |=> !r.capture_flag && !o_capture_irq)
        else $error("capture flag survived its clear");

    chk_capture_low_latch: assert property (
        i_cpu.rd && i_cpu.addr == ADDR_CAPTURE_LOW && !i_cpu.wr
        |=> (r.latch == $past(r.capture[15:8])))
        else $error("latch not loaded on capture low read");

    chk_capture_write_gate: assert property (
        i_cpu.wr && i_cpu.addr == ADDR_CAPTURE_LOW && !cap_top_mode && !cap_event
        |=> $stable(r.capture))
        else $error("capture written outside ceiling mode");

    chk_capture_write_land: assert property (
        wr_capture_low && !cap_event |=> (r.capture == {$past(r.latch), $past(i_cpu.wdata)}))
        else $error("capture write lost in ceiling mode");

    chk_high_read_latch: assert property (
        i_cpu.rd && i_cpu.addr == ADDR_COUNT_HIGH |=> (o_cpu_rdata == $past(r.latch)))
        else $error("counter high read bypassed the latch");

    chk_latch_untouched: assert property (
        i_cpu.rd && !i_cpu.wr && i_cpu.addr != ADDR_COUNT_LOW && i_cpu.addr != ADDR_CAPTURE_LOW
        |=> $stable(r.latch))
        else $error("latch moved on a read that must not load it");

    chk_dual_step_down: assert property (
        dual_slope(wave_mode_field) && tick && !wr_count_low && r.dir == DIR_DOWN && r.count != COUNT_FLOOR
        |=> (r.count == $past(r.count) - 16'h0001))
        else $error("dual-slope count did not step down");

    chk_floor_pulse: assert property (
        tick && r.count == COUNT_FLOOR |=> o_floor_hit)
        else $error("floor pulse missing");

    chk_irq_needs_flag: assert property (
        o_capture_irq |-> o_capture_flag)
        else $error("capture interrupt without its flag");

    cov_capture_event:  cover property (cap_event ##[1:20] (i_cpu.rd && i_cpu.addr == ADDR_CAPTURE_LOW));
    cov_overflow:       cover property (ovf_set ##1 o_overflow_irq);
    cov_count_write:    cover property (tick && wr_count_low);
    cov_dual_slope:     cover property (r.dir == DIR_DOWN ##1 r.dir == DIR_UP);
    cov_filter_capture: cover property (i_cfg.capture_filter_enable && cap_event);

endmodule : timer16_count_capture_core
`default_nettype wire

// File: sim/cpu_bus_model.sv
// Byte-wide processor model that reaches the timer core's 16-bit registers
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model
    import timer16_pkg::*;
(
    input  wire logic       i_clk_sys,
    input  wire logic [7:0] i_rdata,
    output var  cpu_req_t   o_cpu
);
    initial begin
        o_cpu = '0;
    end

    // One strobe cycle, then idle; read data is taken just after the answering edge
    task automatic xfer(input logic rd, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge i_clk_sys);
        o_cpu <= '{rd: rd, wr: !rd, addr: cpu_addr_t'(a), wdata: d};
        @(posedge i_clk_sys);
        o_cpu <= '0;
        #1 q = i_rdata;
    endtask : xfer

    // Never interleaved with another access, so the shared latch cannot be disturbed
    task automatic wr16(input logic [2:0] lo_addr, input logic [15:0] v);
        logic [7:0] q;
        xfer(1'b0, lo_addr + 3'h1, v[15:8], q);
        xfer(1'b0, lo_addr, v[7:0], q);
    endtask : wr16

    // Low byte first: it loads the latch that the high read returns
    task automatic rd16(input logic [2:0] lo_addr, output logic [15:0] v);
        logic [7:0] lo;
        logic [7:0] hi;
        xfer(1'b1, lo_addr, 8'h00, lo);
        xfer(1'b1, lo_addr + 3'h1, 8'h00, hi);
        v = {hi, lo};
    endtask : rd16
endmodule : cpu_bus_model
`default_nettype wire

// File: sim/tb_timer16_count_capture_core.sv
// Self-checking bench for the 16-bit timer core
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
    $display("Error t=%0t got %0h exp %0h", $time, (a), (b)); end end
module tb_timer16_count_capture_core
    import timer16_pkg::*;
;
    logic        i_clk_sys  = 1'b0;
    logic        i_rstn     = 1'b0;
    timer_cfg_t  cfg        = '0;
    timer_cfg_t  nc         = '0;
    logic        cap_ack    = 1'b0;
    logic        pin        = 1'b0;
    logic        port_out   = 1'b0;
    logic        port_dir   = 1'b0;
    logic        cmp        = 1'b0;
    logic        ext        = 1'b0;
    cpu_req_t    cpu;
    logic [7:0]  rdata;
    logic [15:0] cnt, capv, v, w;
    logic        cflag, oflag, cirq, oirq, ceil, flr;
    logic        seen_ceil  = 1'b0;
    logic        seen_floor = 1'b0;
    logic [31:0] seed       = 32'h0001201F;
    int          n_fail = 0, samples_checked = 0, n0, n1;

    timer16_count_capture_core u_timer16_count_capture_core (
        .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_cpu(cpu), .i_cfg(cfg), .i_capture_irq_ack(cap_ack),
        .i_overflow_irq_ack(1'b0), .i_capture_pin(pin), .i_port_out(port_out), .i_port_dir(port_dir),
        .i_comparator_output(cmp), .i_external_count_pin(ext), .o_cpu_rdata(rdata), .o_timer_count(cnt),
        .o_capture_value(capv), .o_capture_flag(cflag), .o_overflow_flag(oflag), .o_capture_irq(cirq),
        .o_overflow_irq(oirq), .o_ceiling_hit(ceil), .o_floor_hit(flr));
    cpu_bus_model u_cpu_bus_model (.i_clk_sys(i_clk_sys), .i_rdata(rdata), .o_cpu(cpu));

    always #4 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        if (ceil === 1'b1) seen_ceil <= 1'b1;
        if (flr === 1'b1) seen_floor <= 1'b1;
    end

    function automatic logic [15:0] rnd16();
        repeat (16) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[15:0];
    endfunction : rnd16
    function automatic logic [15:0] after_ticks(input logic [15:0] s, input int n);
        return s + 16'(n);
    endfunction : after_ticks
    function automatic logic [15:0] bounce(input logic [15:0] s, input logic [15:0] top, input int n);
        int p;
        p = int'(s) + n;
        return (p <= int'(top)) ? 16'(p) : 16'(2 * int'(top) - p);
    endfunction : bounce

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask : cyc
    task automatic setcfg(input timer_cfg_t c);
        @(posedge i_clk_sys);
        cfg <= c;
        cyc(3);
    endtask : setcfg
    task automatic clr(input logic [7:0] b);
        logic [7:0] q8;
        u_cpu_bus_model.xfer(1'b0, 3'h4, b, q8);
    endtask : clr
    task automatic drive(input int k, input logic l);
        @(posedge i_clk_sys);
        case (k)
            0: pin <= l;
            1: cmp <= l;
            2: port_out <= l;
            3: ext <= l;
            default: port_dir <= l;
        endcase
    endtask : drive
    task automatic done(input string s);
        $display("Test %s finished", s);
    endtask : done
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    // Waits a bounded time for a capture; ack picks the serviced-interrupt clear over write-one
    task automatic expect_cap(input logic want, input logic [15:0] e, input logic ack, output int n);
        n = 0;
        while (cflag !== 1'b1 && n < 30) begin
            @(posedge i_clk_sys);
            #1 n++;
        end
        `CHK(cflag, want)
        if (want) begin
            `CHK(capv, e)
            cyc(1);
            `CHK(cirq, cfg.capture_irq_enable)
        end
        if (ack) begin
            drive(5, 1'b0);
            @(posedge i_clk_sys);
            cap_ack <= 1'b1;
            @(posedge i_clk_sys);
            cap_ack <= 1'b0;
        end else begin
            clr(8'h20);
        end
        cyc(1);
        `CHK(cflag, 1'b0)
    endtask : expect_cap

    initial begin
        #100000;
        n_fail++;
        stop_test();
    end

    initial begin
        repeat (4) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        cyc(1);
        `CHK({cnt, cflag, oflag}, {COUNT_RESET, 2'b00})
        nc.capture_irq_enable = 1'b1;
        nc.overflow_irq_enable = 1'b1;
        setcfg(nc);
        v = rnd16();
        u_cpu_bus_model.wr16(3'h0, v);
        `CHK(cnt, v)
        u_cpu_bus_model.rd16(3'h0, w);
        `CHK(w, v)
        cyc(20);
        `CHK(cnt, v)
        done("stop_rw");
        nc.clk_sel = CS_DIV1;
        setcfg(nc);
        v = rnd16() & 16'h7FFF;
        u_cpu_bus_model.wr16(3'h0, v);
        `CHK(cnt, v)
        w = cnt;
        cyc(10);
        `CHK(cnt, after_ticks(w, 10))
        u_cpu_bus_model.wr16(3'h0, 16'hFFF0);
        n0 = 0;
        while (oflag !== 1'b1 && n0 < 40) begin
            cyc(1);
            n0++;
        end
        `CHK(cnt, COUNT_FLOOR)
        `CHK(n0, 16)
        cyc(3);
        `CHK({seen_ceil, seen_floor, oirq}, 3'b111)
        clr(8'h01);
        `CHK(oflag, 1'b0)
        done("count_wrap");
        for (int s = 6; s < 8; s++) begin
            nc.clk_sel = 3'(s);
            setcfg(nc);
            u_cpu_bus_model.wr16(3'h0, 16'h0000);
            repeat (5) begin
                drive(3, 1'b1);
                cyc(4);
                drive(3, 1'b0);
                cyc(4);
            end
            cyc(8);
            `CHK(cnt, 16'h0005)
        end
        done("ext_pin");
        nc.clk_sel = CS_STOP;
        nc.edge_rising = 1'b1;
        setcfg(nc);
        v = rnd16();
        u_cpu_bus_model.wr16(3'h0, v);
        drive(0, 1'b1);
        expect_cap(1'b1, v, 1'b0, n0);
        u_cpu_bus_model.rd16(3'h2, w);
        `CHK(w, v)
        drive(0, 1'b0);
        expect_cap(1'b0, v, 1'b0, n1);
        nc.edge_rising = 1'b0;
        setcfg(nc);
        clr(8'h20);
        drive(0, 1'b1);
        cyc(10);
        `CHK(cflag, 1'b0)
        v = rnd16();
        u_cpu_bus_model.wr16(3'h0, v);
        drive(0, 1'b0);
        expect_cap(1'b1, v, 1'b1, n1);
        nc.capture_filter_enable = 1'b1;
        nc.edge_rising = 1'b1;
        setcfg(nc);
        clr(8'h20);
        v = rnd16();
        u_cpu_bus_model.wr16(3'h0, v);
        drive(0, 1'b1);
        expect_cap(1'b1, v, 1'b0, n1);
        `CHK(n1, n0 + 4)
        drive(0, 1'b0);
        cyc(12);
        drive(0, 1'b1);
        cyc(2);
        drive(0, 1'b0);
        expect_cap(1'b0, v, 1'b0, n1);
        done("capture_pin");
        nc.capture_filter_enable = 1'b0;
        nc.comparator_capture_select = 1'b1;
        setcfg(nc);
        cyc(8);
        clr(8'h20);
        v = rnd16();
        u_cpu_bus_model.wr16(3'h0, v);
        drive(0, 1'b1);
        expect_cap(1'b0, v, 1'b0, n1);
        drive(1, 1'b1);
        expect_cap(1'b1, v, 1'b0, n1);
        nc.comparator_capture_select = 1'b0;
        setcfg(nc);
        drive(4, 1'b1);
        cyc(8);
        clr(8'h20);
        v = rnd16();
        u_cpu_bus_model.wr16(3'h0, v);
        drive(2, 1'b1);
        expect_cap(1'b1, v, 1'b0, n1);
        done("sources");
        u_cpu_bus_model.wr16(3'h2, ~v);
        `CHK(capv, v)
        nc.wave_mode_hi = 2'h3;
        setcfg(nc);
        w = rnd16();
        u_cpu_bus_model.wr16(3'h2, w);
        `CHK(capv, w)
        drive(2, 1'b0);
        cyc(6);
        drive(2, 1'b1);
        expect_cap(1'b0, w, 1'b0, n1);
        done("capture_top");
        w = TOP_8BIT - 16'h0007;
        u_cpu_bus_model.wr16(3'h0, w);
        nc.wave_mode_hi = 2'h0;
        nc.wave_mode_lo = 2'h1;
        nc.clk_sel = CS_DIV8;
        setcfg(nc);
        cyc(80);
        `CHK(cnt, bounce(w, TOP_8BIT, 10))
        done("dual_slope");
        stop_test();
    end
endmodule : tb_timer16_count_capture_core
`default_nettype wire
